// >>> sim/tdrw_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdrw_defs.vh"
module tdrw_cmd_props (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       cmd_ready,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic       rsp_ready,
	input wire logic       chg_valid,
	input wire logic [7:0] change_region_start_high,
	input wire logic [7:0] change_region_end_high,
	input wire logic [7:0] indicator_state,
	input wire logic [7:0] indicator_transition_record,
	input wire logic [7:0] exc_code
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// an invalid operand has just been reported
	sequence s_exc_raise;
		exc_code == `TDRW_EXC_INV_REG && $past(exc_code) == `TDRW_EXC_NONE;
	endsequence
	// a response byte offered but not taken
	sequence s_rsp_stall;
		rsp_valid && !rsp_ready;
	endsequence
	a_rsp_byte_holds: assert property (s_rsp_stall |=> rsp_valid && $stable(rsp_byte))
		else $error("response byte dropped while stalled");
	a_send_blocks_cmd: assert property (rsp_valid |-> !cmd_ready)
		else $error("command taken while answering");
	a_chg_pulse_once: assert property (chg_valid |=> !chg_valid)
		else $error("change entry longer than one cycle");
	a_chg_no_reply: assert property (chg_valid |-> !rsp_valid)
		else $error("change entry during a response");
	a_exc_code_known: assert property (exc_code <= `TDRW_EXC_STORAGE)
		else $error("undefined exception code");
	a_quiet_after_exc: assert property (s_exc_raise |-> (!rsp_valid && !chg_valid) [*2])
		else $error("data or change after invalid operand");
	a_trans_rising_set: assert property
		(((indicator_transition_record[7:4] & ~indicator_state[3:0]) == 4'h0))
		else $error("rising mark on a cleared indicator");
	a_trans_falling_clear: assert property
		(((indicator_transition_record[3:0] & indicator_state[3:0]) == 4'h0))
		else $error("falling mark on a set indicator");
	a_region_in_buffer: assert property (chg_valid |->
		change_region_start_high <= 8'h07 && change_region_end_high <= 8'h07)
		else $error("change region outside buffer");
endmodule
bind tdrw_cmd tdrw_cmd_props PROPS (
	.hclk(hclk),
	.hresetn(hresetn),
	.cmd_ready(cmd_ready),
	.rsp_valid(rsp_valid),
	.rsp_byte(rsp_byte),
	.rsp_ready(rsp_ready),
	.chg_valid(chg_valid),
	.change_region_start_high(change_region_start_high),
	.change_region_end_high(change_region_end_high),
	.indicator_state(indicator_state),
	.indicator_transition_record(indicator_transition_record),
	.exc_code(exc_code)
);
`default_nettype wire

// >>> sim/tdrw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller side: feeds queued command bytes, collects response bytes
module tdrw_host_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// command bytes towards the block
	output var  logic       cmd_valid,
	output var  logic [7:0] cmd_byte,
	output var  logic       cmd_last,
	input  wire logic       cmd_ready,
	// response bytes from the block
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	output var  logic       rsp_ready
);
	logic [8:0] txq[$];        // queued {last, byte}
	logic [7:0] rxq[$];        // bytes received so far
	logic       slow = 1'b0;   // accept only one cycle in four
	logic [1:0] tick;          // stall pacing

	task automatic put(input logic [7:0] b, input logic l);
		txq.push_back({l, b});
	endtask

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_valid <= 1'b0;
			cmd_last  <= 1'b0;
			cmd_byte  <= 8'hA5;
			rsp_ready <= 1'b0;
			tick      <= 2'h0;
		end else begin
			tick      <= tick + 2'h1;
			rsp_ready <= !slow || (tick == 2'h3);
			if (rsp_valid && rsp_ready)
				rxq.push_back(rsp_byte);
			// hold a byte until taken; idle data toggles
			if (!cmd_valid || cmd_ready) begin
				if (txq.size() != 0) begin
					{cmd_last, cmd_byte} <= txq.pop_front();
					cmd_valid            <= 1'b1;
				end else begin
					cmd_valid <= 1'b0;
					cmd_last  <= 1'b0;
					cmd_byte  <= ~cmd_byte;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/test_twinax_display_read_write_cmds.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdrw_defs.vh"
module test_twinax_display_read_write_cmds;
	// bus stimulus
	logic         hclk     = 1'b0;
	logic         hresetn  = 1'b0;
	logic         hsel     = 1'b0;
	logic [31:0]  haddr    = 32'h0;
	logic [1:0]   htrans   = 2'h0;
	logic         hwrite   = 1'b0;
	logic [31:0]  hwdata   = 32'h0;
	// block outputs and link
	wire  [31:0]  hrdata;
	wire          hreadyout, hresp, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_ready, chg_valid;
	wire  [7:0]   cmd_byte, rsp_byte, rs_hi, rs_lo, re_hi, re_lo, ind, trans;
	wire  [7:0]   exc;
	// bookkeeping
	int           num_errors  = 0;
	int           check_count = 0;
	int           cyc         = 0;
	logic [127:0] got;
	logic [31:0]  rd;
	logic [31:0]  chg_seen    = 32'h0;

	always #50 hclk = ~hclk;

	tdrw_cmd DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .rsp_ready(rsp_ready), .chg_valid(chg_valid),
		.change_region_start_high(rs_hi), .change_region_start_low(rs_lo),
		.change_region_end_high(re_hi), .change_region_end_low(re_lo),
		.indicator_state(ind), .indicator_transition_record(trans), .exc_code(exc));

	tdrw_host_model HOST (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));

	// the change pulse lasts one cycle, so latch the region it announces
	always @(posedge hclk)
		if (chg_valid === 1'b1)
			chg_seen <= {rs_hi, rs_lo, re_hi, re_lo};

	// hang guard: the longest scan is about 2000 cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			final_report;
		end
	end

	task automatic final_report;
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		check_count++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// one single transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] want);
		ahb(1'b0, a, 32'h0, rd);
		check({hresp, rd}, {1'b0, want});
	endtask

	// queue n bytes, most significant first
	task automatic send(input int n, input logic [63:0] v);
		for (int k = n - 1; k >= 0; k--)
			HOST.put(v[8*k +: 8], 1'b0);
	endtask

	// wait until every byte is taken and the block is back in idle
	task automatic settle;
		do begin
			do @(posedge hclk); while (HOST.txq.size() != 0 || cmd_valid);
			ahb(1'b0, `TDRW_REG_STATUS, 32'h0, rd);
		end while (rd[4:0] !== 5'h01);
	endtask

	// collect n response bytes, then insist nothing more arrives
	task automatic reply(input int n, input logic [127:0] want);
		got = 128'h0;
		repeat (n) begin
			while (HOST.rxq.size() == 0) @(posedge hclk);
			got = {got[119:0], HOST.rxq.pop_front()};
		end
		check(got, want);
		settle;
		check(HOST.rxq.size(), 0);
	endtask

	task automatic peek(input logic [10:0] a, input logic [7:0] want);
		wr(`TDRW_REG_ADDR, {21'h0, a});
		send(1, `TDRW_RD_DATA_08);
		reply(1, {120'h0, want});
	endtask

	task automatic t_reset;
		rdc(`TDRW_REG_CTRL, 32'h1);
		rdc(`TDRW_REG_ADDR, 32'h0);
		wr(8'h40, 32'hFFFF);
		rdc(8'h40, 32'h0);
	endtask

	task automatic t_regs;
		wr(`TDRW_REG_ADDR, 32'h123);
		wr(`TDRW_REG_CURSOR, 32'h789);
		wr(`TDRW_REG_REF, 32'h456);
		send(1, 8'h01);
		reply(6, 128'h012307890456);
	endtask

	task automatic t_write_ld;
		wr(`TDRW_REG_ADDR, 32'h4D);
		send(5, 64'h0A03112233);
		settle;
		rdc(`TDRW_REG_ADDR, 32'h50);
		rdc(`TDRW_REG_CURSOR, 32'h50);
		check(chg_seen, 32'h004D004F);
		wr(`TDRW_REG_ADDR, 32'h5);
		send(2, 64'h0A0F);
		settle;
		rdc(`TDRW_REG_CURSOR, 32'h6);
		peek(11'h005, 8'h0F);
		peek(11'h04F, 8'h33);
	endtask

	task automatic t_line;
		wr(`TDRW_REG_ADDR, 32'h4E);
		send(1, 8'h02);
		reply(2, 128'h2233);
		rdc(`TDRW_REG_ADDR, 32'h4F);
		wr(`TDRW_REG_ADDR, 32'h780);
		send(1, 8'h02);
		reply(0, 128'h0);
		rdc(`TDRW_REG_EXC, 32'h1);
		rdc(`TDRW_REG_ADDR, 32'h780);
		wr(`TDRW_REG_EXC, 32'h1);
	endtask

	task automatic t_rdata;
		HOST.slow = 1'b1;
		send(1, 8'h58);
		reply(16, 128'h0);
		HOST.slow = 1'b0;
		wr(`TDRW_REG_ADDR, 32'h7D0);
		send(1, `TDRW_RD_DATA_08);
		reply(0, 128'h0);
		rdc(`TDRW_REG_EXC, 32'h1);
		wr(`TDRW_REG_EXC, 32'h1);
	endtask

	// three ids, then zero for an absent device
	task automatic t_id;
		for (int k = 3; k >= 0; k--) begin
			send(1, 32'h03132373 >> (8 * k));
			reply(1, (32'hA1B2C300 >> (8 * k)) & 32'hFF);
		end
	endtask

	task automatic t_limits;
		wr(`TDRW_REG_ADDR, 32'h4D);
		wr(`TDRW_REG_REF, 32'h4F);
		send(1, 8'h04);
		reply(3, 128'h112233);
		rdc(`TDRW_REG_ADDR, 32'h50);
		wr(`TDRW_REG_REF, 32'h4C);
		send(1, 8'h04);
		reply(0, 128'h0);
		rdc(`TDRW_REG_EXC, 32'h1);
		rdc(`TDRW_REG_ADDR, 32'h50);
		wr(`TDRW_REG_EXC, 32'h1);
	endtask

	task automatic t_write_imm;
		send(6, 64'h0B000A0D4142);
		HOST.put(8'h25, 1'b1);
		settle;
		check({rs_hi, rs_lo}, 16'h000A);
		send(3, 64'h05000A);
		reply(3, 128'h414225);
		wr(`TDRW_REG_ADDR, 32'h0A);
		send(1, `TDRW_RD_DATA_18);
		reply(3, 128'h414225);
		rdc(`TDRW_REG_ADDR, 32'h0D);
		wr(`TDRW_REG_ADDR, 32'h50);
		send(1, `TDRW_RD_DATA_18);
		reply(0, 128'h0);
		rdc(`TDRW_REG_EXC, 32'h2);
		wr(`TDRW_REG_EXC, 32'h1);
		wr(`TDRW_REG_ADDR, 32'h14);
		send(2, 64'h0C0D);
		HOST.put(8'h7E, 1'b1);
		settle;
		peek(11'h014, 8'h7E);
	endtask

	task automatic t_ctrl;
		wr(`TDRW_REG_ADDR, 32'h7D0);
		send(1, `TDRW_RD_DATA_08);
		settle;
		send(3, 64'h09115A);
		settle;
		rdc(`TDRW_REG_EXC, 32'h0);
		rdc(`TDRW_REG_CTLB, 32'h5A11);
		send(2, 64'h0920);
		settle;
		ahb(1'b0, `TDRW_REG_CTLB, 32'h0, rd);
		check(rd[7:0], 8'h20);
	endtask

	task automatic t_overflow;
		wr(`TDRW_REG_ADDR, 32'h7CF);
		send(4, 64'h0A025566);
		settle;
		rdc(`TDRW_REG_EXC, 32'h3);
		wr(`TDRW_REG_EXC, 32'h1);
		peek(11'h7CF, 8'h55);
		send(4, 64'h2A052A0A);
		settle;
		check(ind, 8'h0A);
		check(trans, 8'hA5);
	endtask

	initial begin
		foreach (DUT.buf_mem[i]) DUT.buf_mem[i] = 8'h00; // ram has no reset
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_regs;
		t_write_ld;
		t_line;
		t_rdata;
		t_id;
		t_limits;
		t_write_imm;
		t_ctrl;
		t_overflow;
		final_report;
	end
endmodule
`default_nettype wire

// >>> verilog/tdrw_cmd.v
// Operation
// RULE1: read-registers sends six counter bytes
// RULE2: read-line sends buffer to line end
// RULE3: read-line needs visible address, else exception
// RULE4: read-line leaves address at line end
// RULE5: read-id answers identifier or zero data
// RULE6: stripe reader read-data sends sixteen zeros
// RULE7: read-data 08h returns byte at address
// RULE8: read-data 18h reads to attribute, else exception
// RULE9: read-limits validates both counters and order
// RULE10: read-limits sends field, address becomes ref+1
// RULE11: read-immediate validates address, counts, sends bytes
// RULE12: write setup records start; activate-write stores
// RULE13: write-control stores first byte in control one
// RULE14: reset-exception bit clears pending exception
// RULE15: bit 8 set brings second control byte
// RULE16: load-cursor byte 01-0Eh is count, else data
// RULE17: writes increment address, overflow posts storage exception
// RULE18: load-cursor end copies address into cursor
// RULE19: load-cursor end records changed region entry
// RULE20: indicator load stores state and transitions
// RULE21: write-immediate validates address, records region start
// RULE22: write-data checks address, uses as start
// RULE23: buffer holds 2000 bytes, addresses 0-1999
// RULE24: host sends operands upper byte first
// RULE25: failed check changes nothing, sends nothing; a read-data 18h scan that finds no attribute still leaves region_start loaded
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`include "tdrw_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tdrw_cmd #(
	parameter [7:0] ID_BASE = 8'hA1, // arbitrary value
	parameter [7:0] ID_KBD  = 8'hB2, // arbitrary value
	parameter [7:0] ID_IND  = 8'hC3  // arbitrary value
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// command queue from the link receiver
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_byte,
	input  wire        cmd_last,
	output wire        cmd_ready,
	// response bytes to the link transmitter
	output reg         rsp_valid,
	output reg  [7:0]  rsp_byte,
	input  wire        rsp_ready,
	// screen-change notification
	output reg         chg_valid,
	output wire [7:0]  change_region_start_high,
	output wire [7:0]  change_region_start_low,
	output wire [7:0]  change_region_end_high,
	output wire [7:0]  change_region_end_low,
	// indicators and exception
	output reg  [7:0]  indicator_state,
	output reg  [7:0]  indicator_transition_record,
	output reg  [7:0]  exc_code
);

	// one-hot states
	localparam [4:0] S_IDLE  = 5'h01;
	localparam [4:0] S_OPND  = 5'h02;
	localparam [4:0] S_SCAN  = 5'h04;
	localparam [4:0] S_SEND  = 5'h08;
	localparam [4:0] S_WRITE = 5'h10;

	// response sources
	localparam [1:0] SRC_BUF  = 2'h0;
	localparam [1:0] SRC_REGS = 2'h1;
	localparam [1:0] SRC_HOLD = 2'h2;
	localparam [1:0] SRC_ZERO = 2'h3;

	reg  [4:0]  st;               // command state
	reg  [7:0]  op;               // command byte in progress
	reg         nopnd;            // operand byte index
	reg  [7:0]  opnd_hi;          // upper operand byte
	reg  [10:0] ac;               // address counter
	reg  [10:0] ref_ctr;          // reference counter
	reg  [10:0] cursor;           // cursor register
	reg  [10:0] ptr;              // scan and send pointer
	reg  [10:0] cnt;              // bytes left to send or write
	reg  [1:0]  src;              // response source
	reg  [7:0]  hold;             // single held response byte
	reg  [10:0] aw_ptr;           // activate-write pointer
	reg         armed;            // write start recorded
	reg  [15:0] region_start;     // change region start
	reg  [15:0] region_end;       // change region end
	reg  [7:0]  control_byte_one; // first control register
	reg  [7:0]  control_byte_two; // second control register
	reg         enable;           // software gate on command intake
	reg         wr_ph;            // bus write data phase pending
	reg  [7:0]  wa;               // bus write address
	reg  [31:0] rd_val;           // bus read mux
	reg  [7:0]  buf_mem [0:`TDRW_BUF_SIZE-1]; // regeneration buffer

	// address lies inside the regeneration buffer
	function in_buf;
		input [10:0] a;
		in_buf = (a <= `TDRW_BUF_LAST);
	endfunction

	// byte is a field attribute
	function is_attr;
		input [7:0] b;
		is_attr = (b[7:5] == `TDRW_ATTR_TAG);
	endfunction

	// last position of the screen line holding a
	function [10:0] line_end;
		input [10:0] a;
		line_end = a - (a % `TDRW_LINE_LEN) + `TDRW_LINE_LEN - 11'h001;
	endfunction

	// load-cursor first byte is a count
	function is_count;
		input [7:0] b;
		is_count = (b >= `TDRW_CNT_MIN) && (b <= `TDRW_CNT_MAX);
	endfunction

	// counters are sent upper byte first, in register order
	function [7:0] reg_byte;
		input [2:0]  i;
		input [47:0] r;
		reg   [47:0] s;
		begin
			s = r << {i, 3'h0};
			reg_byte = s[47:40];
		end
	endfunction

	// intake stalls while sending or scanning
	assign cmd_ready = enable & (st == S_IDLE || st == S_OPND || st == S_WRITE);
	wire cmd_take = cmd_valid & cmd_ready;
	wire is_aw    = (op[3:0] == `TDRW_OP_ACT_WRITE);

	// a buffer byte arrives this cycle, in a count loop, an activate-write stream or as single byte
	wire wr_go = cmd_take & ((st == S_WRITE && (!is_aw || armed)) ||
		(st == S_OPND && op[3:0] == `TDRW_OP_WR_LDC && op[7:4] != `TDRW_DEV_IND &&
		!nopnd && !is_count(cmd_byte)));
	wire [10:0] wptr  = is_aw ? aw_ptr : ac;
	// RULE17 overflow guard
	wire        wr_ok = wr_go & in_buf(wptr);
	wire [7:0]  buf_rd = buf_mem[ptr];
	wire [10:0] ac_nx  = ac + 11'h001;
	wire [10:0] ptr_nx = ptr + 11'h001;
	wire [10:0] imm_addr = {opnd_hi[2:0], cmd_byte};
	// RULE23 operand range
	wire        imm_ok = (opnd_hi[7:3] == 5'h00) & in_buf(imm_addr);
	wire [10:0] scan_cnt = ptr - region_start[10:0] + 11'h001;

	// response byte source
	wire [7:0] send_byte = (src == SRC_BUF)  ? buf_rd :
		(src == SRC_REGS) ? reg_byte(3'h6 - cnt[2:0],
			{5'h00, ac, 5'h00, cursor, 5'h00, ref_ctr}) :
		(src == SRC_HOLD) ? hold : 8'h00;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign change_region_start_high = region_start[15:8];
	assign change_region_start_low  = region_start[7:0];
	assign change_region_end_high   = region_end[15:8];
	assign change_region_end_low    = region_end[7:0];

	// buffer storage has no reset; screen contents are data, not control
	always @(posedge hclk) begin
		if (wr_ok)
			buf_mem[wptr] <= cmd_byte;
	end

	// bus read mux, unmapped offsets read zero
	always @* begin
		case (haddr[7:0])
			`TDRW_REG_CTRL:   rd_val = {31'h0, enable};
			`TDRW_REG_STATUS: rd_val = {26'h0, armed, st};
			`TDRW_REG_EXC:    rd_val = {24'h0, exc_code};
			`TDRW_REG_ADDR:   rd_val = {21'h0, ac};
			`TDRW_REG_REF:    rd_val = {21'h0, ref_ctr};
			`TDRW_REG_CURSOR: rd_val = {21'h0, cursor};
			`TDRW_REG_CTLB:   rd_val = {16'h0, control_byte_two, control_byte_one};
			`TDRW_REG_IND:    rd_val = {16'h0, indicator_transition_record, indicator_state};
			`TDRW_REG_REGION: rd_val = {region_end, region_start};
			default:          rd_val = 32'h0;
		endcase
	end

	// bus slave, command interpreter and response sender in one process
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= S_IDLE;
			op <= 8'h00;
			nopnd <= 1'b0;
			opnd_hi <= 8'h00;
			ac <= `TDRW_RST_CTR;
			ref_ctr <= `TDRW_RST_CTR;
			cursor <= `TDRW_RST_CTR;
			ptr <= 11'h000;
			cnt <= 11'h000;
			src <= SRC_BUF;
			hold <= 8'h00;
			aw_ptr <= 11'h000;
			armed <= 1'b0;
			region_start <= 16'h0000;
			region_end <= 16'h0000;
			control_byte_one <= 8'h00;
			control_byte_two <= 8'h00;
			indicator_state <= 8'h00;
			indicator_transition_record <= 8'h00;
			exc_code <= `TDRW_EXC_NONE;
			enable <= `TDRW_RST_ENABLE;
			wr_ph <= 1'b0;
			wa <= 8'h00;
			hrdata <= 32'h0;
			rsp_valid <= 1'b0;
			rsp_byte <= 8'h00;
			chg_valid <= 1'b0;
		end else begin
			chg_valid <= 1'b0;
			// address phase: zero wait, read data registered here
			wr_ph <= hsel & hready & htrans[1] & hwrite;
			if (hsel && hready && htrans[1]) begin
				wa <= haddr[7:0];
				if (!hwrite)
					hrdata <= rd_val;
			end
			// data phase write; command logic below overrides counters
			if (wr_ph) begin
				case (wa)
					`TDRW_REG_CTRL:   enable <= hwdata[0];
					`TDRW_REG_EXC:    if (hwdata[0]) exc_code <= `TDRW_EXC_NONE;
					`TDRW_REG_ADDR:   ac <= hwdata[10:0];
					`TDRW_REG_REF:    ref_ctr <= hwdata[10:0];
					`TDRW_REG_CURSOR: cursor <= hwdata[10:0];
					default:          ;
				endcase
			end
			// RULE17 overflow posts storage exception
			if (wr_go && !wr_ok)
				exc_code <= `TDRW_EXC_STORAGE;
			case (st)
				S_IDLE: begin
					if (cmd_take) begin
						op <= cmd_byte;
						nopnd <= 1'b0;
						case (cmd_byte[3:0])
							// RULE1 six register bytes
							`TDRW_OP_RD_REGS: begin
								src <= SRC_REGS;
								cnt <= `TDRW_REGS_LEN;
								st <= S_SEND;
							end
							// RULE3 visible area check
							`TDRW_OP_RD_LINE: begin
								if (ac <= `TDRW_VIS_LAST) begin
									// RULE2 send to line end
									region_start <= {5'h00, ac};
									ptr <= ac;
									cnt <= line_end(ac) - ac + 11'h001;
									src <= SRC_BUF;
									// RULE4 address to line end
									ac <= line_end(ac);
									st <= S_SEND;
								end else
									exc_code <= `TDRW_EXC_INV_REG;
							end
							// RULE5 identifier or zero
							`TDRW_OP_RD_ID: begin
								case (cmd_byte[7:4])
									`TDRW_DEV_BASE: hold <= ID_BASE;
									`TDRW_DEV_KBD:  hold <= ID_KBD;
									`TDRW_DEV_IND:  hold <= ID_IND;
									default:        hold <= 8'h00;
								endcase
								src <= SRC_HOLD;
								cnt <= 11'h001;
								st <= S_SEND;
							end
							`TDRW_OP_RD_DATA: begin
								if (cmd_byte == `TDRW_RD_DATA_08) begin
									// RULE7 single byte read
									if (in_buf(ac)) begin
										ptr <= ac;
										src <= SRC_BUF;
										cnt <= 11'h001;
										st <= S_SEND;
									end else
										exc_code <= `TDRW_EXC_INV_REG;
								end else if (cmd_byte == `TDRW_RD_DATA_18) begin
									// RULE8 scan before sending
									if (in_buf(ac)) begin
										ptr <= ac;
										region_start <= {5'h00, ac};
										st <= S_SCAN;
									end else
										exc_code <= `TDRW_EXC_INV_REG;
								end else begin
									// RULE6 absent stripe reader
									src <= SRC_ZERO;
									cnt <= `TDRW_STRIPE_LEN;
									st <= S_SEND;
								end
							end
							// RULE9 limits validity
							`TDRW_OP_RD_LIMITS: begin
								if (in_buf(ac) && in_buf(ref_ctr) && ref_ctr >= ac) begin
									// RULE10 field send, address update
									ptr <= ac;
									cnt <= ref_ctr - ac + 11'h001;
									src <= SRC_BUF;
									region_start <= {5'h00, ac};
									region_end <= {5'h00, ref_ctr};
									ac <= ref_ctr + 11'h001;
									st <= S_SEND;
								end else
									// RULE25 nothing changes
									exc_code <= `TDRW_EXC_INV_REG;
							end
							// RULE22 address as write start
							`TDRW_OP_WR_DATA: begin
								if (in_buf(ac)) begin
									aw_ptr <= ac;
									armed <= 1'b1;
									region_start <= {5'h00, ac};
								end else
									exc_code <= `TDRW_EXC_INV_REG;
							end
							// RULE12 activate-write data
							`TDRW_OP_ACT_WRITE: begin
								if (!cmd_last)
									st <= S_WRITE;
								else
									armed <= 1'b0;
							end
							`TDRW_OP_RD_IMM, `TDRW_OP_WR_IMM,
							`TDRW_OP_WR_CTRL, `TDRW_OP_WR_LDC:
								st <= S_OPND;
							// unknown commands are dropped
							default: ;
						endcase
					end
				end
				S_OPND: begin
					if (cmd_take) begin
						nopnd <= 1'b1;
						case (op[3:0])
							`TDRW_OP_RD_IMM, `TDRW_OP_WR_IMM: begin
								// RULE24 upper byte first
								if (!nopnd)
									opnd_hi <= cmd_byte;
								else begin
									st <= S_IDLE;
									if (!imm_ok)
										exc_code <= `TDRW_EXC_INV_REG;
									else if (op[3:0] == `TDRW_OP_RD_IMM) begin
										// RULE11 find end, then send
										ptr <= imm_addr;
										region_start <= {5'h00, imm_addr};
										st <= S_SCAN;
									end else begin
										// RULE21 start of change region
										aw_ptr <= imm_addr;
										armed <= 1'b1;
										region_start <= {5'h00, imm_addr};
									end
								end
							end
							`TDRW_OP_WR_CTRL: begin
								if (!nopnd) begin
									// RULE13 first control byte
									control_byte_one <= cmd_byte;
									// RULE14 clear exception status
									if (cmd_byte[`TDRW_CTL_RST_EXC])
										exc_code <= `TDRW_EXC_NONE;
									// RULE15 second byte follows
									if (!cmd_byte[`TDRW_CTL_SECOND])
										st <= S_IDLE;
								end else begin
									control_byte_two <= cmd_byte;
									st <= S_IDLE;
								end
							end
							`TDRW_OP_WR_LDC: begin
								st <= S_IDLE;
								if (op[7:4] == `TDRW_DEV_IND) begin
									// RULE20 indicator state and transitions
									indicator_state <= cmd_byte;
									indicator_transition_record <= {
										cmd_byte[3:0] & ~indicator_state[3:0],
										indicator_state[3:0] & ~cmd_byte[3:0]};
								end else if (is_count(cmd_byte)) begin
									// RULE16 count of following bytes
									region_start <= {5'h00, ac};
									cnt <= {3'h0, cmd_byte};
									st <= S_WRITE;
								end else if (wr_ok) begin
									// RULE16 single byte written
									ac <= ac_nx;
									// RULE18 cursor follows address
									cursor <= ac_nx;
									// RULE19 change entry
									region_start <= {5'h00, ac};
									region_end <= {5'h00, ac};
									chg_valid <= 1'b1;
								end
							end
							default: st <= S_IDLE;
						endcase
					end
				end
				S_SCAN: begin
					// one buffer byte examined per cycle
					if (is_attr(buf_rd) || ptr == `TDRW_BUF_LAST) begin
						if (!is_attr(buf_rd) && op == `TDRW_RD_DATA_18) begin
							// RULE8 no attribute before buffer end
							exc_code <= `TDRW_EXC_ATTR;
							st <= S_IDLE;
						end else begin
							cnt <= scan_cnt;
							ptr <= region_start[10:0];
							src <= SRC_BUF;
							if (op == `TDRW_RD_DATA_18)
								ac <= ptr_nx;
							st <= S_SEND;
						end
					end else
						ptr <= ptr_nx;
				end
				S_SEND: begin
					// holding register refills only when empty or taken
					if (!rsp_valid || rsp_ready) begin
						if (cnt != 11'h000) begin
							rsp_byte <= send_byte;
							rsp_valid <= 1'b1;
							cnt <= cnt - 11'h001;
							ptr <= ptr_nx;
						end else begin
							rsp_valid <= 1'b0;
							st <= S_IDLE;
						end
					end
				end
				S_WRITE: begin
					if (cmd_take) begin
						if (is_aw) begin
							// RULE12 store activate-write data
							if (wr_ok) begin
								aw_ptr <= aw_ptr + 11'h001;
								region_end <= {5'h00, aw_ptr};
							end
							if (cmd_last) begin
								chg_valid <= armed;
								armed <= 1'b0;
								st <= S_IDLE;
							end
						end else begin
							// RULE17 address steps per byte
							if (wr_ok) begin
								ac <= ac_nx;
								region_end <= {5'h00, ac};
							end
							cnt <= cnt - 11'h001;
							if (cnt == 11'h001) begin
								// RULE18 cursor takes final address
								cursor <= wr_ok ? ac_nx : ac;
								// RULE19 change entry
								chg_valid <= 1'b1;
								st <= S_IDLE;
							end
						end
					end
				end
				default: st <= S_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// >>> verilog/tdrw_defs.vh
`ifndef TDRW_DEFS_VH
`define TDRW_DEFS_VH

// screen regeneration buffer geometry
`define TDRW_BUF_SIZE     2000
`define TDRW_BUF_LAST     11'h7CF
`define TDRW_VIS_LAST     11'h77F
`define TDRW_LINE_LEN     11'h050

// command byte: device field [7:4], operation [3:0]
`define TDRW_OP_RD_REGS   4'h1
`define TDRW_OP_RD_LINE   4'h2
`define TDRW_OP_RD_ID     4'h3
`define TDRW_OP_RD_LIMITS 4'h4
`define TDRW_OP_RD_IMM    4'h5
`define TDRW_OP_RD_DATA   4'h8
`define TDRW_OP_WR_CTRL   4'h9
`define TDRW_OP_WR_LDC    4'hA
`define TDRW_OP_WR_IMM    4'hB
`define TDRW_OP_WR_DATA   4'hC
`define TDRW_OP_ACT_WRITE 4'hD

// full read-data command codes
`define TDRW_RD_DATA_08   8'h08
`define TDRW_RD_DATA_18   8'h18

// device and feature addresses
`define TDRW_DEV_BASE     4'h0
`define TDRW_DEV_KBD      4'h1
`define TDRW_DEV_IND      4'h2

// write-data-and-load-cursor byte count range
`define TDRW_CNT_MIN      8'h01
`define TDRW_CNT_MAX      8'h0E

// write-control data word bits, counted within the first byte
`define TDRW_CTL_RST_EXC  4
`define TDRW_CTL_SECOND   0

// attribute bytes carry 001 in their top three bits
`define TDRW_ATTR_TAG     3'h1

// stripe reader read-data and read-registers answer lengths
`define TDRW_STRIPE_LEN   11'h010
`define TDRW_REGS_LEN     11'h006

// exception codes
`define TDRW_EXC_NONE     8'h00
`define TDRW_EXC_INV_REG  8'h01
`define TDRW_EXC_ATTR     8'h02
`define TDRW_EXC_STORAGE  8'h03

// register byte offsets on the bus
`define TDRW_REG_CTRL     8'h00
`define TDRW_REG_STATUS   8'h04
`define TDRW_REG_EXC      8'h08
`define TDRW_REG_ADDR     8'h0C
`define TDRW_REG_REF      8'h10
`define TDRW_REG_CURSOR   8'h14
`define TDRW_REG_CTLB     8'h18
`define TDRW_REG_IND      8'h1C
`define TDRW_REG_REGION   8'h20

// reset values
`define TDRW_RST_ENABLE   1'h1
`define TDRW_RST_CTR      11'h000

`endif
